// file: core/vsad_am_decode.sv
// address modifier classifier
`timescale 1ns/10ps
module vsad_am_decode (
  // modifier in
  input  wire logic               [5:0] am,
  // classification out
  output logic                          am_ok,
  output logic                          am_a24,
  output logic                          am_a32,
  output logic                          am_geo,
  output logic                          am_super,
  output vsad_pkg::vsad_xfer_e          am_xfer
);
  import vsad_pkg::*;

  always_comb begin
    am_ok    = 1'b1;
    am_a24   = 1'b0;
    am_a32   = 1'b0;
    am_geo   = 1'b0;
    am_super = 1'b0;
    am_xfer  = XF_SINGLE;
    case (am)
      AM_A24_SUP_BLT: begin am_a24 = 1'b1; am_super = 1'b1; am_xfer = XF_BLT;  end // R1
      AM_A24_SUP_DATA: begin am_a24 = 1'b1; am_super = 1'b1; end // R1
      AM_A24_SUP_MBLT: begin am_a24 = 1'b1; am_super = 1'b1; am_xfer = XF_MBLT; end // R1
      AM_A24_USR_BLT: begin am_a24 = 1'b1; am_xfer = XF_BLT;  end // R2
      AM_A24_USR_DATA: begin am_a24 = 1'b1; end // R2
      AM_A24_USR_MBLT: begin am_a24 = 1'b1; am_xfer = XF_MBLT; end // R2
      AM_CFG_SPACE: begin am_geo = 1'b1; am_super = 1'b1; end // R5
      AM_A32_SUP_BLT: begin am_a32 = 1'b1; am_super = 1'b1; am_xfer = XF_BLT;  end // R3
      AM_A32_SUP_DATA: begin am_a32 = 1'b1; am_super = 1'b1; end // R3
      AM_A32_SUP_MBLT: begin am_a32 = 1'b1; am_super = 1'b1; am_xfer = XF_MBLT; end // R3
      AM_A32_USR_BLT: begin am_a32 = 1'b1; am_xfer = XF_BLT;  end // R4
      AM_A32_USR_DATA: begin am_a32 = 1'b1; end // R4
      AM_A32_USR_MBLT: begin am_a32 = 1'b1; am_xfer = XF_MBLT; end // R4
      default: begin
        am_ok = 1'b0; // R23
      end
    endcase
  end

endmodule : vsad_am_decode

// file: core/vsad_decoder.sv
// slave address decoder: base, slot and chain selection with register bus
// Functional notes
// R1 - A24 supervisory block, single and 64-bit block modifiers are accepted.
// R2 - A24 user block, single and 64-bit block modifiers are accepted.
// R3 - A32 supervisory block, single and 64-bit block modifiers are accepted.
// R4 - A32 user block, single and 64-bit block modifiers are accepted.
// R5 - configuration modifier is used only for slot accesses, decoded as 24-bit.
// R6 - only upper address bits compare to base, giving a 64 KB window.
// R7 - base comes from rotary switches when control bit 4 is 0, else registers.
// R8 - programmable base: bits 31..24 match high register, 23..16 low register.
// R9 - every reset latches the five slot id lines as slot address.
// R10 - slot access: ignore 31..24, match 23..19, require 18..16 zero.
// R11 - slot access reaches control registers but never the event buffer.
// R12 - without slot id lines no slot addressing; stored slot never selects.
// R13 - slot register writable only without aux connector, used only as tag.
// R14 - chain address with A32 block modifiers means chained block read.
// R15 - chain address with A32 single modifiers means multicast write.
// R16 - multicast only writes; chained transfer only reads of the event buffer.
// R17 - chain address is programmable byte on 31..24, default AA, 23..16 zero.
// R18 - acknowledge daisy chain is a token; only holder transfers, then passes it.
// R19 - first/last pair: 00 inactive, 01 last, 10 first, 11 middle; reset 00.
// R20 - master software sets exactly one first and one last board per chain.
// R21 - each chain in a crate has its own address, same on all its boards.
// R22 - slot address sits in the five top bits of header and end words.
// R23 - unknown modifier or no matching address is never acknowledged.
//
// The AHB-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module vsad_decoder #(
  parameter bit HAS_AUX_CONNECTOR = 1'b1
) (
  // clock, reset, enable
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  input  wire logic                  ce,
  // register bus
  input  wire logic                  hsel,
  input  wire logic           [31:0] haddr,
  input  wire logic            [1:0] htrans,
  input  wire logic                  hwrite,
  input  wire logic            [2:0] hsize,
  input  wire logic           [31:0] hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic                [31:0] hrdata,
  // backplane pins
  input  wire logic           [31:0] vme_addr,
  input  wire logic            [5:0] vme_am,
  input  wire logic                  vme_write_n,
  input  wire logic                  vme_as_n,
  input  wire logic                  vme_iackin_n,
  output logic                       vme_iackout_n,
  // board straps
  input  wire logic            [4:0] slot_id_lines,
  input  wire logic           [15:0] rotary_sw,
  // data path handshake
  input  wire logic                  xfer_done,
  // selection out
  output logic                       sel_base,
  output logic                       sel_geo,
  output logic                       sel_mcst,
  output logic                       sel_cblt,
  output logic                       sel_super,
  output vsad_pkg::vsad_xfer_e       sel_xfer,
  output logic                [15:0] sel_offset,
  output logic                 [4:0] chain_tag
);
  import vsad_pkg::*;

  // ****************************************
  // pin synchronisers
  // ****************************************
  localparam int PIN_W = 62;
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_s1_r;
  logic [PIN_W-1:0] pin_s2_r;
  assign pin_raw = {vme_addr, vme_am, vme_write_n, vme_as_n, vme_iackin_n, slot_id_lines, rotary_sw};

  // left out of reset so the slot lines are already settled when reset latches them
  always_ff @(posedge clk_sys) begin
    if (ce) begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
    end
  end

  logic [31:0] s_addr;
  logic  [5:0] s_am;
  logic        s_write_n;
  logic        s_as_n;
  logic        s_iackin_n;
  logic  [4:0] s_slot;
  logic [15:0] s_sw;
  assign {s_addr, s_am, s_write_n, s_as_n, s_iackin_n, s_slot, s_sw} = pin_s2_r;

  // ****************************************
  // register bus slave
  // ****************************************
  function automatic logic reg_hit(input logic [5:0] idx, input logic [7:0] off);
    reg_hit = (idx == off[7:2]);
  endfunction : reg_hit
  logic        ahb_take;
  logic        dph_valid_r;
  logic        dph_write_r;
  logic  [5:0] dph_idx_r;
  logic        hreadyout_r;
  logic [31:0] hrdata_r;
  logic        wr_en;
  logic        rd_load;
  // only whole-word transfers are taken; anything else passes as idle
  assign ahb_take = hsel & htrans[1] & hready & (hsize == AHB_SIZE_WORD);
  assign wr_en    = dph_valid_r & dph_write_r & hready;
  assign rd_load  = dph_valid_r & ~dph_write_r & ~hreadyout_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dph_valid_r <= 1'b0;
      dph_write_r <= 1'b0;
      dph_idx_r   <= 6'h00;
    end else if (ce && hready) begin
      dph_valid_r <= ahb_take;
      dph_write_r <= hwrite;
      dph_idx_r   <= haddr[7:2];
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  logic       base_src_r;
  logic [7:0] base_hi_r;
  logic [7:0] base_lo_r;
  logic [7:0] chain_addr_r;
  logic [1:0] chain_pos_r;
  logic [4:0] slot_r;
  logic wr_ctrl;
  logic wr_base_hi;
  logic wr_base_lo;
  logic wr_chain_addr;
  logic wr_chain_ctrl;
  logic wr_slot;
  assign wr_ctrl       = wr_en & reg_hit(dph_idx_r, REG_CTRL);
  assign wr_base_hi    = wr_en & reg_hit(dph_idx_r, REG_BASE_HI);
  assign wr_base_lo    = wr_en & reg_hit(dph_idx_r, REG_BASE_LO);
  assign wr_chain_addr = wr_en & reg_hit(dph_idx_r, REG_CHAIN_ADDR);
  assign wr_chain_ctrl = wr_en & reg_hit(dph_idx_r, REG_CHAIN_CTRL);
  assign wr_slot       = wr_en & reg_hit(dph_idx_r, REG_SLOT) & ~HAS_AUX_CONNECTOR; // R13

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      base_src_r   <= BASE_SRC_RST; // R7
      base_hi_r    <= BASE_HI_RST;
      base_lo_r    <= BASE_LO_RST;
      chain_addr_r <= CHAIN_ADDR_RST; // R17
      chain_pos_r  <= CHAIN_POS_RST; // R19
    end else if (ce) begin
      if (wr_ctrl) base_src_r <= hwdata[CTRL_BASE_SRC_BIT]; // R7
      if (wr_base_hi) base_hi_r <= hwdata[7:0];
      if (wr_base_lo) base_lo_r <= hwdata[7:0];
      if (wr_chain_addr) chain_addr_r <= hwdata[7:0];
      if (wr_chain_ctrl) chain_pos_r <= hwdata[CHAIN_FIRST_BIT:CHAIN_LAST_BIT];
    end
  end

  // slot value is caught by a clocked process while reset is held
  always_ff @(posedge clk_sys) begin
    if (rst) slot_r <= HAS_AUX_CONNECTOR ? s_slot : SLOT_RST; // R9
    else if (ce && wr_slot) slot_r <= hwdata[4:0]; // R13
  end

  // ****************************************
  // modifier classification
  // ****************************************
  logic       am_ok;
  logic       am_a24;
  logic       am_a32;
  logic       am_geo;
  logic       am_super;
  vsad_xfer_e am_xfer;
  vsad_am_decode u_am_decode (
    .am       (s_am),
    .am_ok    (am_ok),
    .am_a24   (am_a24),
    .am_a32   (am_a32),
    .am_geo   (am_geo),
    .am_super (am_super),
    .am_xfer  (am_xfer)
  );

  // ****************************************
  // address matching
  // ****************************************
  logic [15:0] base16;
  logic        base_hit;
  logic        geo_hit;
  logic        chain_active;
  logic        chain_hit;
  logic        mcst_hit;
  logic        cblt_hit;
  logic        in_evb;
  assign base16       = base_src_r ? {base_hi_r, base_lo_r} : s_sw; // R7 R8
  assign in_evb       = (s_addr[15:0] < EVB_LIMIT);
  assign base_hit     = am_ok & (am_a24 | am_a32)
                      & (am_a32 ? (s_addr[31:16] == base16) : (s_addr[23:16] == base16[7:0])); // R6 R8
  assign geo_hit      = HAS_AUX_CONNECTOR & am_geo // R5 R12
                      & (s_addr[23:19] == slot_r) & (s_addr[18:16] == GEO_PAD_ZERO) & ~in_evb; // R10 R11
  assign chain_active = (chain_pos_r != CH_INACTIVE); // R19
  assign chain_hit    = chain_active & am_a32 & (am_xfer != XF_MBLT)
                      & (s_addr[31:24] == chain_addr_r) & (s_addr[23:16] == CHAIN_PAD_ZERO); // R17
  assign mcst_hit     = chain_hit & (am_xfer == XF_SINGLE) & ~s_write_n; // R15 R16
  assign cblt_hit     = chain_hit & (am_xfer == XF_BLT) & s_write_n & in_evb; // R14 R16

  // chain use wins over the board's own base, so a shared address never answers twice
  logic hit_any;
  logic hit_chain;
  logic hit_base_sel;
  assign hit_chain    = mcst_hit | cblt_hit;
  assign hit_base_sel = base_hit & ~hit_chain;
  assign hit_any      = hit_chain | hit_base_sel | geo_hit; // R23

  // ****************************************
  // cycle sequencer
  // ****************************************
  vsad_state_e state_r;
  vsad_state_e state_nxt;
  logic        as_prev_r;
  logic        as_fall;
  logic        token_held;
  logic        is_last;
  logic        chain_cyc_r;
  assign as_fall    = as_prev_r & ~s_as_n;
  assign is_last    = (chain_pos_r == CH_LAST);
  // first board owns the token from the start, the rest wait for it upstream
  assign token_held = (chain_pos_r == CH_FIRST) | ~s_iackin_n; // R18 R20

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (as_fall && hit_any) state_nxt = (hit_chain && !token_held) ? ST_WAIT : ST_SEL; // R18
      end
      ST_WAIT: begin
        if (s_as_n) state_nxt = ST_IDLE;
        else if (token_held) state_nxt = ST_SEL; // R18
      end
      ST_SEL: begin
        if (s_as_n) state_nxt = ST_IDLE;
        else if (chain_cyc_r && xfer_done && !is_last) state_nxt = ST_PASS; // R18
      end
      ST_PASS: begin
        if (s_as_n) state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  logic start;
  assign start = (state_r == ST_IDLE) & as_fall & hit_any;

  logic hit_base_r;
  logic hit_geo_r;
  logic hit_mcst_r;
  logic hit_cblt_r;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r     <= ST_IDLE;
      as_prev_r   <= 1'b1;
      {chain_cyc_r, hit_base_r, hit_geo_r, hit_mcst_r, hit_cblt_r} <= 5'h00;
    end else if (ce) begin
      state_r   <= state_nxt;
      as_prev_r <= s_as_n;
      if (start) begin
        chain_cyc_r <= hit_chain;
        hit_base_r  <= hit_base_sel;
        hit_geo_r   <= geo_hit;
        hit_mcst_r  <= mcst_hit;
        hit_cblt_r  <= cblt_hit;
      end
    end
  end

  // ****************************************
  // registered outputs
  // ****************************************
  logic       sel_on;
  logic       iackout_nxt;
  logic       sel_base_r;
  logic       sel_geo_r;
  logic       sel_mcst_r;
  logic       sel_cblt_r;
  logic       sel_super_r;
  vsad_xfer_e sel_xfer_r;
  logic [15:0] sel_offset_r;
  logic       iackout_r;
  assign sel_on = (state_nxt == ST_SEL);
  // idle or inactive boards hand the chain straight on; a token holder releases it only once done
  assign iackout_nxt = ((state_nxt == ST_IDLE) || !chain_active) ? s_iackin_n
                       : (state_nxt != ST_PASS); // R18

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      {sel_base_r, sel_geo_r, sel_mcst_r, sel_cblt_r, sel_super_r} <= 5'h00;
      sel_xfer_r   <= XF_SINGLE;
      sel_offset_r <= 16'h0000;
      iackout_r    <= 1'b1;
    end else if (ce) begin
      sel_base_r <= sel_on & (start ? hit_base_sel : hit_base_r);
      sel_geo_r  <= sel_on & (start ? geo_hit : hit_geo_r);
      sel_mcst_r <= sel_on & (start ? mcst_hit : hit_mcst_r);
      sel_cblt_r <= sel_on & (start ? cblt_hit : hit_cblt_r);
      iackout_r  <= iackout_nxt;
      if (start) begin
        sel_super_r  <= am_super;
        sel_xfer_r   <= am_xfer;
        sel_offset_r <= s_addr[15:0]; // R10
      end
    end
  end

  // ****************************************
  // read mux and bus answer
  // ****************************************
  logic [31:0] rd_data;
  assign rd_data =
    reg_hit(dph_idx_r, REG_CTRL)       ? (32'(base_src_r) << CTRL_BASE_SRC_BIT) :
    reg_hit(dph_idx_r, REG_BASE_HI)    ? {24'h0, base_hi_r} :
    reg_hit(dph_idx_r, REG_BASE_LO)    ? {24'h0, base_lo_r} :
    reg_hit(dph_idx_r, REG_CHAIN_ADDR) ? {24'h0, chain_addr_r} :
    reg_hit(dph_idx_r, REG_CHAIN_CTRL) ? {30'h0, chain_pos_r} :
    reg_hit(dph_idx_r, REG_SLOT)       ? {27'h0, slot_r} :
    reg_hit(dph_idx_r, REG_STATUS)     ? {24'h0, state_r, hit_cblt_r, hit_mcst_r, hit_geo_r, hit_base_r} :
    reg_hit(dph_idx_r, REG_TAG)        ? (32'(slot_r) << TAG_LSB) : // R22
    32'h0;

  // reads take one wait state so that read data always leaves a flip-flop
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hreadyout_r <= 1'b1;
      hrdata_r    <= 32'h00000000;
    end else if (ce) begin
      if (rd_load) begin
        hreadyout_r <= 1'b1;
        hrdata_r    <= rd_data;
      end else if (ahb_take && !hwrite) hreadyout_r <= 1'b0;
    end
  end

  assign hreadyout     = hreadyout_r;
  assign hresp         = 1'b0;
  assign hrdata        = hrdata_r;
  assign vme_iackout_n = iackout_r;
  assign sel_base      = sel_base_r;
  assign sel_geo       = sel_geo_r;
  assign sel_mcst      = sel_mcst_r;
  assign sel_cblt      = sel_cblt_r;
  assign sel_super     = sel_super_r;
  assign sel_xfer      = sel_xfer_r;
  assign sel_offset    = sel_offset_r;
  assign chain_tag     = slot_r; // R22

endmodule : vsad_decoder

// file: core/vsad_pkg.sv
// constants, codes and types shared by the slave address decoder
package vsad_pkg;

  // ****************************************
  // address modifier codes
  // ****************************************
  localparam logic [5:0] AM_A24_SUP_BLT   = 6'h3F;
  localparam logic [5:0] AM_A24_SUP_DATA  = 6'h3D;
  localparam logic [5:0] AM_A24_SUP_MBLT  = 6'h3C;
  localparam logic [5:0] AM_A24_USR_BLT   = 6'h3B;
  localparam logic [5:0] AM_A24_USR_DATA  = 6'h39;
  localparam logic [5:0] AM_A24_USR_MBLT  = 6'h38;
  localparam logic [5:0] AM_CFG_SPACE     = 6'h2F;
  localparam logic [5:0] AM_A32_SUP_BLT   = 6'h0F;
  localparam logic [5:0] AM_A32_SUP_DATA  = 6'h0D;
  localparam logic [5:0] AM_A32_SUP_MBLT  = 6'h0C;
  localparam logic [5:0] AM_A32_USR_BLT   = 6'h0B;
  localparam logic [5:0] AM_A32_USR_DATA  = 6'h09;
  localparam logic [5:0] AM_A32_USR_MBLT  = 6'h08;

  // ****************************************
  // register byte offsets (low address byte)
  // ****************************************
  localparam logic [7:0] REG_CTRL         = 8'h00;
  localparam logic [7:0] REG_BASE_HI      = 8'h04;
  localparam logic [7:0] REG_BASE_LO      = 8'h08;
  localparam logic [7:0] REG_CHAIN_ADDR   = 8'h0C;
  localparam logic [7:0] REG_CHAIN_CTRL   = 8'h10;
  localparam logic [7:0] REG_SLOT         = 8'h14;
  localparam logic [7:0] REG_STATUS       = 8'h18;
  localparam logic [7:0] REG_TAG          = 8'h1C;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int         CTRL_BASE_SRC_BIT = 4;
  localparam int         CHAIN_FIRST_BIT   = 1;
  localparam int         CHAIN_LAST_BIT    = 0;
  localparam int         TAG_LSB           = 27;
  localparam logic       BASE_SRC_RST      = 1'b0;
  localparam logic [7:0] BASE_HI_RST       = 8'h00;
  localparam logic [7:0] BASE_LO_RST       = 8'h00;
  localparam logic [7:0] CHAIN_ADDR_RST    = 8'hAA;
  localparam logic [1:0] CHAIN_POS_RST     = 2'h0;
  localparam logic [4:0] SLOT_RST          = 5'h00;

  // chain position codes: {first, last}
  localparam logic [1:0] CH_INACTIVE       = 2'h0;
  localparam logic [1:0] CH_LAST           = 2'h1;
  localparam logic [1:0] CH_FIRST          = 2'h2;
  localparam logic [1:0] CH_MIDDLE         = 2'h3;

  // ****************************************
  // address fields and bus codes
  // ****************************************
  localparam logic [15:0] EVB_LIMIT        = 16'h0800;
  localparam logic [2:0]  GEO_PAD_ZERO     = 3'h0;
  localparam logic [7:0]  CHAIN_PAD_ZERO   = 8'h00;
  localparam logic [2:0]  AHB_SIZE_WORD    = 3'h2;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    XF_SINGLE = 2'h0,
    XF_BLT    = 2'h1,
    XF_MBLT   = 2'h2
  } vsad_xfer_e;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WAIT = 4'h2,
    ST_SEL  = 4'h4,
    ST_PASS = 4'h8
  } vsad_state_e;

endpackage : vsad_pkg

// file: tb/vsad_chk.sv
// concurrent checks on the slave address decoder ports
`timescale 1ns/10ps
module vsad_chk (
  // clock and reset
  input wire logic                 clk_sys,
  input wire logic                 rst,
  // backplane side
  input wire logic          [31:0] vme_addr,
  input wire logic           [5:0] vme_am,
  input wire logic                 vme_write_n,
  input wire logic                 vme_as_n,
  input wire logic                 vme_iackout_n,
  input wire logic                 xfer_done,
  // selection side
  input wire logic                 sel_base,
  input wire logic                 sel_geo,
  input wire logic                 sel_mcst,
  input wire logic                 sel_cblt,
  input wire logic                 sel_super,
  input wire logic           [1:0] sel_xfer,
  input wire logic          [15:0] sel_offset,
  input wire logic           [4:0] chain_tag
);
  import vsad_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire any_sel = sel_base | sel_geo | sel_mcst | sel_cblt;
  wire am_ok = vme_am inside {6'h3F, 6'h3D, 6'h3C, 6'h3B, 6'h39, 6'h38, 6'h2F, 6'h0F, 6'h0D, 6'h0C, 6'h0B, 6'h09, 6'h08};
  // ****************************************
  // selection rules
  // ****************************************
  chk_one_path: assert property ($onehot0({sel_base, sel_geo, sel_mcst, sel_cblt}))
    else $error("more than one path selected");
  chk_bad_am: assert property ($fell(vme_as_n) && !am_ok |-> ##4 !any_sel [*4])
    else $error("unknown modifier selected the board");
  chk_idle_quiet: assert property (vme_as_n [*6] |-> !any_sel)
    else $error("selection without strobe");
  chk_mcst_write: assert property ($rose(sel_mcst) |-> !vme_write_n && sel_xfer == XF_SINGLE)
    else $error("multicast not a single write");
  chk_cblt_read: assert property ($rose(sel_cblt) |-> vme_write_n && sel_xfer == XF_BLT && sel_offset < EVB_LIMIT)
    else $error("chained transfer not a buffer block read");
  chk_geo_match: assert property ($rose(sel_geo) |-> vme_am == AM_CFG_SPACE && sel_offset >= EVB_LIMIT
    && vme_addr[23:16] == {chain_tag, GEO_PAD_ZERO}) else $error("slot access mismatch");
  chk_base_kind: assert property ($rose(sel_base) |-> sel_super == vme_am[2] && sel_offset == vme_addr[15:0]
    && sel_xfer == (vme_am[1] ? XF_BLT : (vme_am[0] ? XF_SINGLE : XF_MBLT))) else $error("base transfer kind wrong");
  chk_token_pass: assert property (sel_cblt && xfer_done |=> !vme_iackout_n && !sel_cblt)
    else $error("token not passed after share");
  chk_reset_idle: assert property (disable iff (1'b0) rst |=> !any_sel && vme_iackout_n)
    else $error("not idle after reset");
endmodule : vsad_chk
bind vsad_decoder vsad_chk i_vsad_chk (.clk_sys, .rst, .vme_addr, .vme_am, .vme_write_n, .vme_as_n,
  .vme_iackout_n, .xfer_done, .sel_base, .sel_geo, .sel_mcst, .sel_cblt, .sel_super, .sel_xfer,
  .sel_offset, .chain_tag);

// file: tb/vsad_decoder_tb.sv
// self-checking bench for the slave address decoder
`timescale 1ns/10ps
module vsad_decoder_tb;
  import vsad_pkg::*;
  typedef struct packed {logic [31:0] a; logic [5:0] m; logic w; logic [3:0] s;} vsad_row_s;
  logic        clk_sys = 1'b0, rst = 1'b1, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0, xfer_done = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, vme_addr, q;
  logic  [1:0] htrans = 2'h0;
  logic  [2:0] hsize = 3'h0;
  logic  [5:0] vme_am;
  logic  [4:0] slot_id_lines = 5'h05, chain_tag;
  logic [15:0] rotary_sw = 16'hEE11, sel_offset;
  logic  [3:0] s;
  logic        hreadyout, hresp, vme_write_n, vme_as_n, vme_iackin_n, vme_iackout_n;
  logic        sel_base, sel_geo, sel_mcst, sel_cblt, sel_super;
  vsad_xfer_e  sel_xfer;
  int          errors = 0, n_checks = 0;
  vsad_row_s rows [29] = '{
    '{32'hEE110040, 6'h0F, 1'b0, 4'h1}, '{32'hEE110040, 6'h0D, 1'b0, 4'h1}, '{32'hEE110040, 6'h0C, 1'b0, 4'h1},
    '{32'hEE110040, 6'h0B, 1'b0, 4'h1}, '{32'hEE110040, 6'h09, 1'b0, 4'h1}, '{32'hEE110040, 6'h08, 1'b0, 4'h1},
    '{32'h00110040, 6'h3F, 1'b0, 4'h1}, '{32'h00110040, 6'h3D, 1'b0, 4'h1}, '{32'h00110040, 6'h3C, 1'b0, 4'h1},
    '{32'h00110040, 6'h3B, 1'b0, 4'h1}, '{32'h00110040, 6'h39, 1'b0, 4'h1}, '{32'h00110040, 6'h38, 1'b0, 4'h1},
    '{32'hEE120040, 6'h0D, 1'b0, 4'h0}, '{32'hEE11FFFC, 6'h0D, 1'b0, 4'h1}, '{32'hEE110040, 6'h3E, 1'b0, 4'h0},
    '{32'h00281000, 6'h2F, 1'b0, 4'h2}, '{32'hFF281000, 6'h2F, 1'b0, 4'h2}, '{32'h00291000, 6'h2F, 1'b0, 4'h0},
    '{32'h00280400, 6'h2F, 1'b0, 4'h0}, '{32'h00301000, 6'h2F, 1'b0, 4'h0}, '{32'hAA000100, 6'h0D, 1'b1, 4'h4},
    '{32'hAA000100, 6'h09, 1'b1, 4'h4}, '{32'hAA000100, 6'h0D, 1'b0, 4'h0}, '{32'hAA000100, 6'h0F, 1'b0, 4'h8},
    '{32'hAA000100, 6'h0B, 1'b0, 4'h8}, '{32'hAA000100, 6'h0C, 1'b0, 4'h0}, '{32'hAA000100, 6'h0F, 1'b1, 4'h0},
    '{32'hAA010100, 6'h0F, 1'b0, 4'h0}, '{32'hAA000100, 6'h3F, 1'b0, 4'h0}};
  logic [7:0] rst_reg [6] = '{REG_CTRL, REG_BASE_HI, REG_BASE_LO, REG_CHAIN_ADDR, REG_CHAIN_CTRL, 8'h40};
  logic [7:0] rst_val [6] = '{8'h00, BASE_HI_RST, BASE_LO_RST, CHAIN_ADDR_RST, 8'h00, 8'h00};

  always #2.5 clk_sys = ~clk_sys;

  vsad_decoder i_vsad_decoder (.clk_sys, .rst, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .vme_addr, .vme_am, .vme_write_n, .vme_as_n,
    .vme_iackin_n, .vme_iackout_n, .slot_id_lines, .rotary_sw, .xfer_done, .sel_base, .sel_geo,
    .sel_mcst, .sel_cblt, .sel_super, .sel_xfer, .sel_offset, .chain_tag);
  vsad_vme_master i_vsad_vme_master (.clk_sys, .vme_addr, .vme_am, .vme_write_n, .vme_as_n, .vme_iackin_n);

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    {hsel, htrans, haddr, hwrite, hsize} <= {1'b1, 2'h2, 24'h0, a, w, AHB_SIZE_WORD};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : ahb

  // hold the strobe for len cycles and gather every path that selected the board
  task automatic run(input logic [31:0] a, input logic [5:0] m, input logic w, input int tok, input int len,
                     output logic [3:0] v);
    v = 4'h0;
    fork
      i_vsad_vme_master.cyc(a, m, w, tok, len);
      repeat (len + 8) @(posedge clk_sys) v |= {sel_cblt, sel_mcst, sel_geo, sel_base};
    join
  endtask : run

  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run

  initial begin
    #100us;
    errors++;
    complete_run;
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk(chain_tag, 32'h05);
    chk({hresp, sel_cblt, sel_mcst, sel_geo, sel_base, vme_iackout_n}, 32'h1);
    foreach (rst_reg[i]) begin
      ahb(1'b0, rst_reg[i], 32'h0, q);
      chk(q, rst_val[i]);
    end
    ahb(1'b1, REG_CHAIN_CTRL, CH_FIRST, q);
    foreach (rows[i]) begin
      run(rows[i].a, rows[i].m, rows[i].w, 0, 10, s);
      chk(s, rows[i].s);
    end
    ahb(1'b1, REG_BASE_HI, 32'h12, q);
    ahb(1'b1, REG_BASE_LO, 32'h34, q);
    ahb(1'b1, REG_CTRL, 32'h10, q);
    run(32'h12340040, 6'h0D, 1'b0, 0, 10, s);
    chk(s, 32'h1);
    run(32'hEE110040, 6'h0D, 1'b0, 0, 10, s);
    chk(s, 32'h0);
    // every board of one chain carries the same byte
    ahb(1'b1, REG_CHAIN_ADDR, 32'h55, q);
    run(32'h55000100, 6'h0D, 1'b1, 0, 10, s);
    chk(s, 32'h4);
    ahb(1'b1, REG_SLOT, 32'h1F, q);
    ahb(1'b0, REG_SLOT, 32'h0, q);
    chk(q, 32'h05);
    ahb(1'b0, REG_TAG, 32'h0, q);
    chk(q, {5'h05, 27'h0});
    ahb(1'b1, REG_CHAIN_CTRL, CH_MIDDLE, q);
    fork
      run(32'h55000100, 6'h0F, 1'b0, 6, 20, s);
      begin
        repeat (8) @(posedge clk_sys);
        chk(sel_cblt, 32'h0);
        repeat (8) @(posedge clk_sys);
        chk(sel_cblt, 32'h1);
        xfer_done <= 1'b1;
        @(posedge clk_sys) xfer_done <= 1'b0;
        @(posedge clk_sys);
        chk(vme_iackout_n, 32'h0);
      end
    join
    ahb(1'b1, REG_CHAIN_CTRL, CH_INACTIVE, q);
    run(32'h55000100, 6'h0F, 1'b0, 2, 12, s);
    chk(s, 32'h0);
    ahb(1'b1, REG_CHAIN_CTRL, CH_LAST, q);
    run(32'h55000100, 6'h0F, 1'b0, 2, 12, s);
    chk(s, 32'h8);
    // a second reset must take the new slot lines
    slot_id_lines <= 5'h0A;
    rst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk(chain_tag, 32'h0A);
    ahb(1'b0, REG_CHAIN_CTRL, 32'h0, q);
    chk(q, 32'h0);
    run(32'h00501000, 6'h2F, 1'b0, 0, 10, s);
    chk(s, 32'h2);
    complete_run;
  end
endmodule : vsad_decoder_tb

// file: tb/vsad_vme_master.sv
// backplane master and upstream token model
`timescale 1ns/10ps
module vsad_vme_master (
  // clock
  input wire logic clk_sys,
  // backplane pins
  output logic [31:0] vme_addr,
  output logic  [5:0] vme_am,
  output logic        vme_write_n,
  output logic        vme_as_n,
  output logic        vme_iackin_n
);
  initial begin
    vme_addr = 32'h0;
    vme_am = 6'h0;
    vme_write_n = 1'b1;
    vme_as_n = 1'b1;
    vme_iackin_n = 1'b1;
  end
  // address set a cycle before the strobe; tok 0 means upstream never hands over
  task automatic cyc(input logic [31:0] a, input logic [5:0] m, input logic w, input int tok, input int len);
    vme_addr <= a;
    vme_am <= m;
    vme_write_n <= ~w;
    @(posedge clk_sys) vme_as_n <= 1'b0;
    for (int i = 1; i <= len; i++) @(posedge clk_sys) if (i == tok) vme_iackin_n <= 1'b0;
    vme_as_n <= 1'b1;
    vme_iackin_n <= 1'b1;
    // released lines show garbage so stale values never pass
    @(posedge clk_sys) vme_addr <= ~a;
    vme_am <= ~m;
    repeat (4) @(posedge clk_sys);
  endtask : cyc
endmodule : vsad_vme_master
